// File: core/anm_pkg.sv
// constants and types for the auto-negotiation management register bank
package anm_pkg;
   // register indices on the management bus
   localparam logic [4:0] REG_ADV   = 5'h04;
   localparam logic [4:0] REG_LPA   = 5'h05;
   localparam logic [4:0] REG_EXP   = 5'h06;
   localparam logic [4:0] REG_NP    = 5'h07;
   localparam logic [4:0] REG_LPNP  = 5'h08;
   localparam logic [4:0] REG_RXERR = 5'h15;
   localparam logic [4:0] REG_INT   = 5'h1b;
   // advertisement fields
   localparam int ADV_PAUSE = 10;
   localparam int ADV_T4    = 9;
   localparam int ADV_TXFD  = 8;
   localparam int ADV_TX    = 7;
   localparam int ADV_10FD  = 6;
   localparam int ADV_10    = 5;
   localparam int SEL_MSB   = 4;
   // partner ability fields
   localparam int LPA_NP    = 15;
   localparam int LPA_ACK   = 14;
   localparam int LPA_RSVD  = 12;
   // expansion fields
   localparam int EXP_PDF   = 4;
   localparam int EXP_LPNPA = 3;
   localparam int EXP_NPA   = 2;
   localparam int EXP_PR    = 1;
   localparam int EXP_LPANA = 0;
   // next-page fields, local and partner
   localparam int NP_NEXT   = 15;
   localparam int NP_RSVD   = 14;
   localparam int NP_MP     = 13;
   localparam int NP_ACK2   = 12;
   localparam int NP_TOG    = 11;
   localparam int MSG_MSB   = 10;
   // interrupt control/status fields
   localparam int INT_JAB_EN = 15;
   localparam int INT_JAB    = 7;
   // sticky flag slots
   localparam int FLG_PDF  = 0;
   localparam int FLG_PR   = 1;
   localparam int FLG_JAB  = 2;
   localparam int FLG_NUM  = 3;
   // reset values
   localparam logic [4:0]  SEL_IEEE     = 5'h01;
   localparam logic [15:0] LPA_RST      = 16'h0001;
   localparam logic        ADV10_RST    = 1'h1;
   localparam logic        NP_MP_RST    = 1'h1;
   localparam logic [10:0] NP_MSG_RST   = 11'h001;
   localparam logic [15:0] RXERR_RST    = 16'h0000;
   localparam logic        LOCAL_NP_ABLE = 1'h1;
   // management frame layout, counts are last-bit indices
   localparam logic [1:0] OP_READ  = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [3:0] CNT_OP   = 4'h1;
   localparam logic [3:0] CNT_ADDR = 4'h4;
   localparam logic [3:0] CNT_TA   = 4'h1;
   localparam logic [3:0] CNT_DATA = 4'hf;

   typedef enum logic [2:0] {MD_IDLE, MD_START, MD_OP, MD_PHY, MD_REG, MD_TA, MD_DATA}
      anm_mdst_e;
endpackage

// File: core/anm_sticky_flag.sv
// latched-high flags, cleared on request unless set again in the same cycle
`timescale 1ns/1ps
module anm_sticky_flag #(
   parameter int W = 1
) (
   input  wire logic         mclk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] setIn,
   input  wire logic [W-1:0] clrIn,
   output logic      [W-1:0] flagOut
);
   typedef struct packed {
      logic [W-1:0] flag;
   } anm_flag_s;

   anm_flag_s s_r;
   anm_flag_s s_nxt;

   if (W < 1) begin : gBadW
      $error("anm_sticky_flag needs W of at least 1");
   end

   always_comb begin
      s_nxt = s_r;
      // set wins so an event at the clearing read is not lost
      s_nxt.flag = (s_r.flag & ~clrIn) | setIn;
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign flagOut = s_r.flag;

   AST_SET_WINS: assert property (@(posedge mclk) disable iff (!arst_n)
      setIn != '0 |=> (flagOut & $past(setIn)) == $past(setIn)) // (R24)
      else $error("sticky flag lost a set");
endmodule

// File: core/anm_mdio_serial.sv
// serial management frame engine: sampled mdc, bidirectional data pin
`timescale 1ns/1ps
module anm_mdio_serial
   import anm_pkg::*;
#(
   parameter logic [4:0] PHY_ADDR = 5'h01
) (
   input  wire logic        mclk,
   input  wire logic        arst_n,
   input  wire logic        mdc,
   input  wire logic        mdioIn,
   output logic             mdioOut,
   output logic             mdioOe,
   output logic             rdReq,
   output logic             wrReq,
   output logic [4:0]       regAddr,
   output logic [15:0]      wrData,
   input  wire logic [15:0] rdData
);
   typedef struct packed {
      anm_mdst_e   st;
      logic [3:0]  cnt;
      logic [15:0] sh;
      logic        isRd;
      logic [4:0]  phy;
      logic [4:0]  ra;
      logic        mdcPrev;
      logic        oe;
      logic        dout;
      logic        rdReq;
      logic        wrReq;
   } anm_mdio_s;

   anm_mdio_s s_r;
   anm_mdio_s s_nxt;
   logic      match;

   assign match = (s_r.phy == PHY_ADDR);

   always_comb begin
      s_nxt = s_r;
      s_nxt.rdReq = 1'b0;
      s_nxt.wrReq = 1'b0;
      s_nxt.mdcPrev = mdc;
      // everything moves on the sampled rising edge of mdc
      if (mdc && !s_r.mdcPrev) begin
         case (s_r.st)
            MD_IDLE: begin
               // any run of ones is idle, so suppressed preamble is accepted
               if (!mdioIn) s_nxt.st = MD_START;
            end
            MD_START: begin
               s_nxt.st = mdioIn ? MD_OP : MD_IDLE;
               s_nxt.cnt = CNT_OP;
            end
            MD_OP: begin
               s_nxt.sh = {s_r.sh[14:0], mdioIn};
               s_nxt.cnt = s_r.cnt - 4'h1;
               if (s_r.cnt == 4'h0) begin
                  s_nxt.isRd = ({s_r.sh[0], mdioIn} == OP_READ);
                  s_nxt.cnt = CNT_ADDR;
                  s_nxt.st = ({s_r.sh[0], mdioIn} == OP_READ ||
                              {s_r.sh[0], mdioIn} == OP_WRITE) ? MD_PHY : MD_IDLE;
               end
            end
            MD_PHY: begin
               s_nxt.phy = {s_r.phy[3:0], mdioIn};
               s_nxt.cnt = s_r.cnt - 4'h1;
               if (s_r.cnt == 4'h0) begin
                  s_nxt.st = MD_REG;
                  s_nxt.cnt = CNT_ADDR;
               end
            end
            MD_REG: begin
               s_nxt.ra = {s_r.ra[3:0], mdioIn};
               s_nxt.cnt = s_r.cnt - 4'h1;
               if (s_r.cnt == 4'h0) begin
                  s_nxt.st = MD_TA;
                  s_nxt.cnt = CNT_TA;
                  s_nxt.rdReq = s_r.isRd && match; // (R23)
               end
            end
            MD_TA: begin
               s_nxt.cnt = s_r.cnt - 4'h1;
               if (s_r.isRd && match) begin
                  s_nxt.oe = 1'b1;
                  s_nxt.dout = 1'b0;
               end
               if (s_r.cnt == 4'h0) begin
                  s_nxt.st = MD_DATA;
                  s_nxt.cnt = CNT_DATA;
                  if (s_r.isRd && match) begin
                     s_nxt.dout = rdData[15];
                     s_nxt.sh = {rdData[14:0], 1'b0};
                  end
               end
            end
            MD_DATA: begin
               s_nxt.sh = s_r.oe ? {s_r.sh[14:0], 1'b0} : {s_r.sh[14:0], mdioIn};
               s_nxt.dout = s_r.sh[15];
               s_nxt.cnt = s_r.cnt - 4'h1;
               if (s_r.cnt == 4'h0) begin
                  s_nxt.st = MD_IDLE;
                  s_nxt.oe = 1'b0;
                  s_nxt.dout = 1'b0;
                  s_nxt.wrReq = !s_r.isRd && match; // (R23)
               end
            end
            default: s_nxt.st = MD_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign mdioOut = s_r.dout;
   assign mdioOe  = s_r.oe;
   assign rdReq   = s_r.rdReq;
   assign wrReq   = s_r.wrReq;
   assign regAddr = s_r.ra;
   assign wrData  = s_r.sh;

   AST_DRIVE_ONLY_IN_ANSWER: assert property (@(posedge mclk) disable iff (!arst_n)
      mdioOe |-> (s_r.st == MD_TA || s_r.st == MD_DATA)) // (R23)
      else $error("data pin driven outside a read answer");
   AST_TA_ZERO: assert property (@(posedge mclk) disable iff (!arst_n)
      $rose(mdioOe) |-> !mdioOut && s_r.st == MD_TA) // (R23)
      else $error("turnaround bit not driven low");
   COV_READ: cover property (@(posedge mclk) disable iff (!arst_n) rdReq);
   COV_WRITE: cover property (@(posedge mclk) disable iff (!arst_n) wrReq);
endmodule

// File: core/anm_regbank.sv
// auto-negotiation management register bank behind the serial management port
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// What this block does
// (R1) writable pause advertisement bit, resets to 0
// (R2) writable speed/duplex advertisement bits, 10M resets 1, T4 reads 0
// (R3) at reset 100TX-FD, 100TX, 10FD advertisement loaded from straps
// (R4) local and partner selector fields reset to 00001, local writable
// (R5) partner acknowledge bit set once a link code word arrives
// (R6) partner next-page and remote fault bits read-only, reset 0
// (R7) partner pause two-bit field read-only, resets 0
// (R8) partner speed and duplex abilities read-only, reset 0
// (R9) parallel detection fault flag latched high until read
// (R10) partner next-page capability reported read-only, reset 0
// (R11) own next-page capability bit reads 1
// (R12) page received flag latched high until read
// (R13) partner auto-negotiation capability reported read-only, reset 0
// (R14) writable local next-page flag, software marks last page, reset 0
// (R15) writable message-page bit reset 1, second-acknowledge reset 0
// (R16) local toggle bit reflects previously transmitted word's toggle
// (R17) writable eleven-bit local message field, resets to 001
// (R18) partner next-page word captured read-only, all fields reset 0
// (R19) partner toggle bit is inverse of previous transmitted toggle
// (R20) sixteen-bit receive error packet counter, resets to zero
// (R21) jabber status bit set on jabber, cleared by its read
// (R22) interrupt output only while jabber flag and its enable set
// (R23) registers reached by index through standard management frames
// (R24) latched flags clear on read unless condition still present
module anm_regbank
   import anm_pkg::*;
#(
   parameter logic [4:0] PHY_ADDR = 5'h01
) (
   input  wire logic        mclk,
   input  wire logic        arst_n,
   input  wire logic        mdc,
   input  wire logic        mdioIn,
   output logic             mdioOut,
   output logic             mdioOe,
   input  wire logic        speedStrap,
   input  wire logic        duplexStrap,
   input  wire logic        lcwRcvd,
   input  wire logic [15:0] lcwData,
   input  wire logic        npRcvd,
   input  wire logic [15:0] npData,
   input  wire logic        txToggle,
   input  wire logic        partnerAnAble,
   input  wire logic        pdfDetect,
   input  wire logic        jabberDetect,
   input  wire logic        rxErrPkt,
   output logic [15:0]      advWord,
   output logic [15:0]      localNpWord,
   output logic             intOut
);
   typedef struct packed {
      logic        strapDone;
      logic        advPause;
      logic        advTxFd;
      logic        advTx;
      logic        adv10Fd;
      logic        adv10;
      logic [4:0]  advSel;
      logic [15:0] lpa;
      logic [15:0] lpnp;
      logic        npNext;
      logic        npMp;
      logic        npAck2;
      logic [10:0] npMsg;
      logic        txTog;
      logic        lpAnAble;
      logic [15:0] receiveErrorCount;
      logic        jabEn;
      logic [15:0] rdData;
   } anm_bank_s;

   localparam anm_bank_s BANK_RST = '{
      strapDone: 1'h0, advPause: 1'h0, advTxFd: 1'h0, advTx: 1'h0,
      adv10Fd: 1'h0, adv10: ADV10_RST, advSel: SEL_IEEE, lpa: LPA_RST,
      lpnp: 16'h0000, npNext: 1'h0, npMp: NP_MP_RST, npAck2: 1'h0,
      npMsg: NP_MSG_RST, txTog: 1'h0, lpAnAble: 1'h0,
      receiveErrorCount: RXERR_RST, jabEn: 1'h0, rdData: 16'h0000};

   anm_bank_s           s_r;
   anm_bank_s           s_nxt;
   logic                rdReq;
   logic                wrReq;
   logic [4:0]          regAddr;
   logic [15:0]         wrData;
   logic [FLG_NUM-1:0]  flagSet;
   logic [FLG_NUM-1:0]  flagClr;
   logic [FLG_NUM-1:0]  flags;

   ////////////////////////////////////////////////////////////////////////////
   // word assembly, shared by the read path and the outputs

   function automatic logic [15:0] advOf(input anm_bank_s b);
      logic [15:0] w;
      w = 16'h0000;
      w[ADV_PAUSE] = b.advPause; // (R1)
      w[ADV_T4]    = 1'b0; // (R2)
      w[ADV_TXFD]  = b.advTxFd;
      w[ADV_TX]    = b.advTx;
      w[ADV_10FD]  = b.adv10Fd;
      w[ADV_10]    = b.adv10;
      w[SEL_MSB:0] = b.advSel; // (R4)
      return w;
   endfunction

   function automatic logic [15:0] npOf(input anm_bank_s b);
      logic [15:0] w;
      w = 16'h0000;
      w[NP_NEXT]    = b.npNext; // (R14)
      w[NP_MP]      = b.npMp; // (R15)
      w[NP_ACK2]    = b.npAck2;
      w[NP_TOG]     = b.txTog; // (R16)
      w[MSG_MSB:0]  = b.npMsg; // (R17)
      return w;
   endfunction

   function automatic logic [15:0] regWord(input anm_bank_s b,
                                           input logic [FLG_NUM-1:0] f,
                                           input logic [4:0] a);
      logic [15:0] w;
      w = 16'h0000;
      case (a)
         REG_ADV:   w = advOf(b);
         // base page read back as captured, ack forced on capture
         REG_LPA:   w = b.lpa; // (R6) (R7) (R8)
         REG_EXP: begin
            w[EXP_PDF]   = f[FLG_PDF]; // (R9)
            w[EXP_LPNPA] = b.lpa[LPA_NP]; // (R10)
            w[EXP_NPA]   = LOCAL_NP_ABLE; // (R11)
            w[EXP_PR]    = f[FLG_PR]; // (R12)
            w[EXP_LPANA] = b.lpAnAble; // (R13)
         end
         REG_NP:    w = npOf(b);
         REG_LPNP:  w = b.lpnp; // (R18)
         REG_RXERR: w = b.receiveErrorCount;
         REG_INT: begin
            w[INT_JAB_EN] = b.jabEn;
            w[INT_JAB]    = f[FLG_JAB]; // (R21)
         end
         default:   w = 16'h0000;
      endcase
      return w;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // management port and latched flags

   anm_mdio_serial #(
      .PHY_ADDR (PHY_ADDR)
   ) uSerial (
      .mclk    (mclk),
      .arst_n  (arst_n),
      .mdc     (mdc),
      .mdioIn  (mdioIn),
      .mdioOut (mdioOut),
      .mdioOe  (mdioOe),
      .rdReq   (rdReq),
      .wrReq   (wrReq),
      .regAddr (regAddr),
      .wrData  (wrData),
      .rdData  (s_r.rdData)
   );

   // a new base page or next page both count as a received page
   assign flagSet[FLG_PDF] = pdfDetect; // (R9)
   assign flagSet[FLG_PR]  = lcwRcvd | npRcvd; // (R12)
   assign flagSet[FLG_JAB] = jabberDetect; // (R21)
   assign flagClr[FLG_PDF] = rdReq && regAddr == REG_EXP; // (R24)
   assign flagClr[FLG_PR]  = rdReq && regAddr == REG_EXP; // (R24)
   assign flagClr[FLG_JAB] = rdReq && regAddr == REG_INT; // (R21)

   anm_sticky_flag #(
      .W (FLG_NUM)
   ) uFlags (
      .mclk    (mclk),
      .arst_n  (arst_n),
      .setIn   (flagSet),
      .clrIn   (flagClr),
      .flagOut (flags)
   );

   ////////////////////////////////////////////////////////////////////////////
   // register state

   always_comb begin
      s_nxt = s_r;
      s_nxt.txTog = txToggle; // (R16)
      s_nxt.lpAnAble = partnerAnAble; // (R13)
      // straps are caught one edge after release, never under reset
      if (!s_r.strapDone) begin
         s_nxt.strapDone = 1'b1;
         s_nxt.advTxFd = speedStrap & duplexStrap; // (R3)
         s_nxt.advTx = speedStrap; // (R3)
         s_nxt.adv10Fd = duplexStrap; // (R3)
      end
      if (lcwRcvd) begin
         s_nxt.lpa = lcwData;
         s_nxt.lpa[LPA_RSVD] = 1'b0;
         s_nxt.lpa[LPA_ACK] = 1'b1; // (R5)
      end
      if (npRcvd) begin
         s_nxt.lpnp = npData; // (R18)
         // bit 14 is the partner's acknowledge here, kept as received
         s_nxt.lpnp[NP_TOG] = ~txToggle; // (R19)
      end
      // saturates so a long error burst never wraps to a small count
      if (rxErrPkt && s_r.receiveErrorCount != 16'hffff) begin
         s_nxt.receiveErrorCount = s_r.receiveErrorCount + 16'h0001; // (R20)
      end
      // read value frozen before the clearing read takes effect
      if (rdReq) begin
         s_nxt.rdData = regWord(s_r, flags, regAddr); // (R23)
      end
      if (wrReq) begin
         case (regAddr)
            REG_ADV: begin
               s_nxt.advPause = wrData[ADV_PAUSE]; // (R1)
               s_nxt.advTxFd  = wrData[ADV_TXFD]; // (R2)
               s_nxt.advTx    = wrData[ADV_TX];
               s_nxt.adv10Fd  = wrData[ADV_10FD];
               s_nxt.adv10    = wrData[ADV_10];
               s_nxt.advSel   = wrData[SEL_MSB:0]; // (R4)
            end
            REG_NP: begin
               s_nxt.npNext = wrData[NP_NEXT]; // (R14)
               s_nxt.npMp   = wrData[NP_MP]; // (R15)
               s_nxt.npAck2 = wrData[NP_ACK2]; // (R15)
               s_nxt.npMsg  = wrData[MSG_MSB:0]; // (R17)
            end
            REG_INT: s_nxt.jabEn = wrData[INT_JAB_EN]; // (R22)
            default: s_nxt.jabEn = s_r.jabEn;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= BANK_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign advWord     = advOf(s_r);
   assign localNpWord = npOf(s_r);
   assign intOut      = flags[FLG_JAB] & s_r.jabEn; // (R22)

   ////////////////////////////////////////////////////////////////////////////
   // checks

   AST_PAUSE_WRITE: assert property (@(posedge mclk) disable iff (!arst_n)
      wrReq && regAddr == REG_ADV |=> advWord[ADV_PAUSE] == $past(wrData[ADV_PAUSE])) // (R1)
      else $error("pause advertisement not written");
   AST_T4_ZERO: assert property (@(posedge mclk) disable iff (!arst_n)
      wrReq && regAddr == REG_ADV |=> !advWord[ADV_T4]) // (R2)
      else $error("T4 advertisement became writable");
   AST_STRAP: assert property (@(posedge mclk) disable iff (!arst_n)
      !s_r.strapDone ##1 !$past(wrReq) |-> advWord[ADV_TXFD] ==
      ($past(speedStrap) & $past(duplexStrap)) && advWord[ADV_TX] == $past(speedStrap)) // (R3)
      else $error("strap load wrong");
   AST_ACK_SET: assert property (@(posedge mclk) disable iff (!arst_n)
      lcwRcvd |=> s_r.lpa[LPA_ACK] ##1 s_r.lpa[LPA_ACK]) // (R5)
      else $error("partner acknowledge not set");
   AST_PDF_HOLD: assert property (@(posedge mclk) disable iff (!arst_n)
      flags[FLG_PDF] && !(rdReq && regAddr == REG_EXP) |=> flags[FLG_PDF]) // (R9)
      else $error("fault flag dropped without a read");
   AST_PR_SET: assert property (@(posedge mclk) disable iff (!arst_n)
      lcwRcvd || npRcvd |=> flags[FLG_PR]) // (R12)
      else $error("page received flag not set");
   AST_NP_WRITE: assert property (@(posedge mclk) disable iff (!arst_n)
      wrReq && regAddr == REG_NP |=> localNpWord[NP_NEXT] == $past(wrData[NP_NEXT])
      && localNpWord[MSG_MSB:0] == $past(wrData[MSG_MSB:0])) // (R14)
      else $error("next page word not written");
   AST_TOGGLE: assert property (@(posedge mclk) disable iff (!arst_n)
      npRcvd |=> s_r.lpnp[NP_TOG] != $past(txToggle)) // (R19)
      else $error("partner toggle polarity wrong");
   AST_COUNT: assert property (@(posedge mclk) disable iff (!arst_n)
      rxErrPkt && s_r.receiveErrorCount != 16'hffff |=>
      s_r.receiveErrorCount == $past(s_r.receiveErrorCount) + 16'h0001) // (R20)
      else $error("receive error count missed a packet");
   AST_JAB_CLEAR: assert property (@(posedge mclk) disable iff (!arst_n)
      rdReq && regAddr == REG_INT && !jabberDetect |=> !flags[FLG_JAB] && !intOut) // (R21)
      else $error("jabber flag not cleared by read");
   AST_INT: assert property (@(posedge mclk) disable iff (!arst_n)
      $rose(intOut) |-> s_r.jabEn && (flags[FLG_JAB] && $past(jabberDetect) ||
      $past(wrReq))) // (R22)
      else $error("interrupt without enabled jabber");

   COV_EXP_READ: cover property (@(posedge mclk) disable iff (!arst_n)
      rdReq && regAddr == REG_EXP && flags[FLG_PR]);
   COV_ADV_WRITE: cover property (@(posedge mclk) disable iff (!arst_n)
      wrReq && regAddr == REG_ADV);
   COV_INT: cover property (@(posedge mclk) disable iff (!arst_n) $rose(intOut));
endmodule

// File: dv/anm_sme_model.sv
// station management model driving the serial management port
`timescale 1ns/1ps
module anm_sme_model
   import anm_pkg::*;
(
   input  wire logic mclk,
   output logic      mdc,
   output logic      mdioIn,
   input  wire logic mdioOut,
   input  wire logic mdioOe
);
   logic stOut;
   logic stEn;
   // released pin floats high through the pull-up
   assign mdioIn = mdioOe ? mdioOut : (stEn ? stOut : 1'b1);
   initial begin
      mdc = 1'b0;
      stOut = 1'b1;
      stEn = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // no preamble; pin let go from turnaround on reads, clock parked low after
   task automatic frame(input logic [1:0] op, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd);
      logic [31:0] bits;
      bits = {2'b01, op, 5'h01, ra, 2'b10, wd};
      for (int i = 31; i >= 0; i--) begin
         @(posedge mclk) #1;
         mdc = 1'b0;
         stEn = !(op == OP_READ && i < 18);
         stOut = bits[i];
         repeat (3) @(posedge mclk);
         #1 rd = {rd[14:0], mdioIn};
         mdc = 1'b1;
         repeat (4) @(posedge mclk);
      end
      @(posedge mclk) #1;
      mdc = 1'b0;
      stEn = 1'b0;
      repeat (4) @(posedge mclk);
   endtask
endmodule

// File: dv/anm_regbank_tb.sv
// self-checking bench for the auto-negotiation register bank
`timescale 1ns/1ps
module anm_regbank_tb
   import anm_pkg::*;
;
   logic        mclk, arst_n, mdc, mdioIn, mdioOut, mdioOe, speedStrap, duplexStrap;
   logic        lcwRcvd, npRcvd, txToggle, partnerAnAble, pdfDetect, jabberDetect;
   logic        rxErrPkt, intOut;
   logic [15:0] lcwData, npData, advWord, localNpWord, rd;
   int          num_errors, n_checks;
   logic [4:0]  ra [8] = '{REG_ADV, REG_LPA, REG_EXP, REG_NP, REG_LPNP, REG_RXERR, REG_INT, 5'h1f};
   logic [15:0] rv [8] = '{16'h00a1, 16'h0001, 16'h0004, 16'h2001, 16'h0, 16'h0, 16'h0, 16'h0};
   anm_regbank dut (.mclk(mclk), .arst_n(arst_n), .mdc(mdc), .mdioIn(mdioIn),
      .mdioOut(mdioOut), .mdioOe(mdioOe), .speedStrap(speedStrap),
      .duplexStrap(duplexStrap), .lcwRcvd(lcwRcvd), .lcwData(lcwData), .npRcvd(npRcvd),
      .npData(npData), .txToggle(txToggle), .partnerAnAble(partnerAnAble),
      .pdfDetect(pdfDetect), .jabberDetect(jabberDetect), .rxErrPkt(rxErrPkt),
      .advWord(advWord), .localNpWord(localNpWord), .intOut(intOut));
   anm_sme_model sme (.mclk(mclk), .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut),
      .mdioOe(mdioOe));
   always #4 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [4:0] a, input logic [15:0] e);
      sme.frame(OP_READ, a, 16'h0, rd);
      chk(rd, e);
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      sme.frame(OP_WRITE, a, d, rd);
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #200000;
      num_errors++;
      close_out;
   end
   initial begin
      {mclk, arst_n, lcwRcvd, npRcvd, txToggle, partnerAnAble} = '0;
      {pdfDetect, jabberDetect, rxErrPkt, duplexStrap, lcwData, npData} = '0;
      speedStrap = 1'b1;
      repeat (12) @(posedge mclk);
      #1 arst_n = 1'b1;
      repeat (4) @(posedge mclk);
      chk(advWord, 16'h00a1);
      for (int i = 0; i < 8; i++)
         rdc(ra[i], rv[i]);
      $display("test reset done");
      wr(REG_ADV, 16'hffff);
      wr(REG_LPA, 16'hffff);
      #1 txToggle = 1'b1;
      wr(REG_NP, 16'h8000);
      chk(advWord, 16'h05ff);
      chk(localNpWord, 16'h8800);
      rdc(REG_ADV, 16'h05ff);
      rdc(REG_LPA, 16'h0001);
      rdc(REG_NP, 16'h8800);
      $display("test write done");
      @(posedge mclk) #1;
      {txToggle, partnerAnAble, lcwData, npData} = {1'b0, 1'b1, 16'hbee1, 16'hf7ff};
      {lcwRcvd, npRcvd, pdfDetect} = 3'b111;
      @(posedge mclk) #1;
      {lcwRcvd, npRcvd, pdfDetect} = 3'b000;
      rdc(REG_LPA, 16'heee1);
      rdc(REG_LPNP, 16'hffff);
      rdc(REG_EXP, 16'h001f);
      rdc(REG_EXP, 16'h000d);
      $display("test link done");
      repeat (3) begin
         @(posedge mclk) #1 rxErrPkt = 1'b1;
         @(posedge mclk) #1 rxErrPkt = 1'b0;
      end
      rdc(REG_RXERR, 16'h0003);
      rdc(REG_RXERR, 16'h0003);
      @(posedge mclk) #1 jabberDetect = 1'b1;
      @(posedge mclk) #1 jabberDetect = 1'b0;
      repeat (2) @(posedge mclk);
      chk({15'h0, intOut}, 16'h0000);
      wr(REG_INT, 16'hffff);
      chk({15'h0, intOut}, 16'h0001);
      rdc(REG_INT, 16'h8080);
      chk({15'h0, intOut}, 16'h0000);
      rdc(REG_INT, 16'h8000);
      $display("test count and jabber done");
      @(posedge mclk) #1 arst_n = 1'b0;
      duplexStrap = 1'b1;
      repeat (2) @(posedge mclk);
      #1 arst_n = 1'b1;
      repeat (2) @(posedge mclk);
      #1 chk(advWord, 16'h01e1);
      rdc(REG_INT, 16'h0000);
      $display("test strap reload done");
      close_out;
   end
endmodule
